// File: sreg_pkg.sv
// Constants for the safety register error-correction guard
package sreg_pkg;
  localparam int REG_COUNT = 4;
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam int CODE_W = 13;
  localparam int CNT_W = 3;
  localparam logic [2:0] RESET_ERR_START = 3'h1;
  localparam logic [2:0] RESET_ERR_MAX = 3'h7;
  localparam logic [DATA_W-1:0] CFG_RESET = 8'h00;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RESET_PULSE_NS = 1000;
  localparam int RESET_PULSE_CYC =
    (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] PULSE_LOAD = 4'(RESET_PULSE_CYC);
endpackage

// File: sreg_guard.sv
// Hamming guard over fail-safe configuration registers and key check
//
// Notes on behaviour
// (RULE1) Init phase: configuration writes open, no checking applied.
// (RULE2) After init, only fail-safe registers are Hamming protected.
// (RULE3) One flipped bit is corrected invisibly and a flag is set.
// (RULE4) Two flipped bits: no fix, flag set, reset and fail-safe driven.
// (RULE5) Controller writes the release key once fault gone, counter zero; sreg_mcu_model waits for counter zero only, not for the fault to go.
// (RULE6) Release key is seed bit-reversed and inverted; only it counts.
// (RULE7) Fail-safe releases only with no fault, counter zero, good key.
// (RULE8) Start-up or low-power resume: counter to one, fail-safe asserted.
// (RULE9) Double error increments reset counter, always triggers fail-safe.
// (RULE10) Error flags stay set until software clears them.
`timescale 1ns/10ps
module sreg_guard (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic safetyInitPhase,
  input wire logic cfgWrite,
  input wire logic [1:0] cfgAddr,
  input wire logic [7:0] cfgData,
  output logic [7:0] cfgReadData,
  input wire logic keyWrite,
  input wire logic [7:0] failsafeReleaseKey,
  input wire logic [7:0] watchdogSeedValue,
  input wire logic faultPresent,
  input wire logic lowPowerOffResume,
  input wire logic goodRefreshDecrement,
  input wire logic errClear,
  input wire logic upsetInject,
  input wire logic [1:0] upsetAddr,
  input wire logic [12:0] upsetMask,
  output logic singleErrFlag,
  output logic doubleErrorDetect,
  output logic [2:0] resetErrCount,
  output logic keyAccepted,
  output logic reset_out_n,
  output logic failsafe_out_n
);

  // Codeword: bit 0 overall parity, bits 1..12 Hamming positions
  function automatic logic [12:0] encode(input logic [7:0] d);
    logic [12:0] c;
    c = '0;
    {c[12], c[11], c[10], c[9], c[7], c[6], c[5], c[3]} = d;
    c[1] = c[3] ^ c[5] ^ c[7] ^ c[9] ^ c[11];
    c[2] = c[3] ^ c[6] ^ c[7] ^ c[10] ^ c[11];
    c[4] = c[5] ^ c[6] ^ c[7] ^ c[12];
    c[8] = c[9] ^ c[10] ^ c[11] ^ c[12];
    c[0] = ^c[12:1];
    return c;
  endfunction

  function automatic logic [3:0] syndrome(input logic [12:0] c);
    logic [3:0] s;
    s = '0;
    for (int i = 1; i < 13; i++) begin
      if (c[i]) begin
        s = s ^ 4'(i);
      end
    end
    return s;
  endfunction

  function automatic logic [12:0] correct(input logic [12:0] c);
    logic [12:0] f;
    logic [3:0] s;
    f = c;
    s = syndrome(c);
    if (^c) begin
      if (s == 4'h0) begin
        f[0] = ~c[0];
      end else if (s <= 4'hC) begin
        f[s] = ~c[s];
      end
    end
    return f;
  endfunction

  function automatic logic [7:0] extract(input logic [12:0] c);
    return {c[12], c[11], c[10], c[9], c[7], c[6], c[5], c[3]};
  endfunction

  logic [12:0] codeMem [sreg_pkg::REG_COUNT];
  logic [1:0] scanIdx;
  logic [12:0] scanWord;
  logic [12:0] fixedCode;
  logic sedHit;
  logic dedHit;
  logic [7:0] expectedKey;
  logic [3:0] pulseCnt;

  // Scrub runs only once configuration is locked
  assign scanWord = codeMem[scanIdx];
  assign fixedCode = correct(scanWord);
  assign sedHit = !safetyInitPhase && (^scanWord)
    && (syndrome(scanWord) <= 4'hC); // RULE2 RULE3
  assign dedHit = !safetyInitPhase && !(^scanWord)
    && (syndrome(scanWord) != 4'h0); // RULE2 RULE4
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      expectedKey[i] = ~watchdogSeedValue[7 - i]; // RULE6
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      scanIdx <= 2'h0;
    end else begin
      scanIdx <= scanIdx + 2'h1;
    end
  end

  // Upset port models a particle hit on the storage cells
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      for (int i = 0; i < sreg_pkg::REG_COUNT; i++) begin
        codeMem[i] <= encode(sreg_pkg::CFG_RESET);
      end
    end else begin
      if (safetyInitPhase && cfgWrite) begin
        codeMem[cfgAddr] <= encode(cfgData); // RULE1
      end else if (sedHit) begin
        codeMem[scanIdx] <= fixedCode; // RULE3
      end
      if (upsetInject) begin
        codeMem[upsetAddr] <= codeMem[upsetAddr] ^ upsetMask;
      end
    end
  end

  // Reads see corrected data once configuration is locked, even before the scrub reaches it
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cfgReadData <= sreg_pkg::CFG_RESET;
    end else if (safetyInitPhase) begin
      cfgReadData <= extract(codeMem[cfgAddr]); // RULE1
    end else begin
      cfgReadData <= extract(correct(codeMem[cfgAddr])); // RULE3
    end
  end

  // Set wins over clear so no event is lost
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      singleErrFlag <= 1'b0;
      doubleErrorDetect <= 1'b0;
    end else begin
      singleErrFlag <= sedHit || (singleErrFlag && !errClear); // RULE10
      doubleErrorDetect <= dedHit
        || (doubleErrorDetect && !errClear); // RULE10
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      resetErrCount <= sreg_pkg::RESET_ERR_START; // RULE8
    end else if (lowPowerOffResume) begin
      resetErrCount <= sreg_pkg::RESET_ERR_START; // RULE8
    end else if (dedHit) begin
      if (resetErrCount != sreg_pkg::RESET_ERR_MAX) begin
        resetErrCount <= resetErrCount + 3'h1; // RULE9
      end
    end else if (goodRefreshDecrement && resetErrCount != 3'h0) begin
      resetErrCount <= resetErrCount - 3'h1;
    end
  end

  // A new fault demands a fresh key
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      keyAccepted <= 1'b0;
    end else if (dedHit || lowPowerOffResume || !failsafe_out_n
                 && keyAccepted && faultPresent) begin
      keyAccepted <= 1'b0;
    end else if (keyWrite) begin
      keyAccepted <= (failsafeReleaseKey == expectedKey); // RULE6 RULE5
    end else if (failsafe_out_n) begin
      keyAccepted <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      failsafe_out_n <= 1'b0; // RULE8
    end else if (dedHit || lowPowerOffResume) begin
      failsafe_out_n <= 1'b0; // RULE4 RULE9
    end else if (!faultPresent && resetErrCount == 3'h0 && keyAccepted) begin
      failsafe_out_n <= 1'b1; // RULE7
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pulseCnt <= 4'h0;
      reset_out_n <= 1'b1;
    end else if (dedHit) begin
      pulseCnt <= sreg_pkg::PULSE_LOAD;
      reset_out_n <= 1'b0; // RULE4
    end else if (pulseCnt > 4'h1) begin
      pulseCnt <= pulseCnt - 4'h1;
    end else begin
      pulseCnt <= 4'h0;
      reset_out_n <= 1'b1;
    end
  end

  a_init_no_flag: assert property (@(posedge core_clk) // RULE1
    disable iff (!rstn)
    safetyInitPhase && !singleErrFlag |=> !singleErrFlag)
    else $error("single flag set during init phase");
  // A faulty word must stay untouched while configuration is open
  a_scrub_locked: assert property (@(posedge core_clk) // RULE2
    disable iff (!rstn)
    safetyInitPhase && !upsetInject && !cfgWrite
      |=> codeMem[$past(scanIdx)] == $past(scanWord))
    else $error("scrub active during init phase");
  a_single_fix: assert property (@(posedge core_clk) // RULE3
    disable iff (!rstn)
    sedHit && !upsetInject |=> singleErrFlag
      && codeMem[$past(scanIdx)] == $past(fixedCode))
    else $error("single error not corrected");
  a_double_outs: assert property (@(posedge core_clk) // RULE4
    disable iff (!rstn)
    dedHit |=> !reset_out_n && !failsafe_out_n && doubleErrorDetect)
    else $error("double error did not drive outputs");
  a_reset_width: assert property (@(posedge core_clk) // RULE4
    disable iff (!rstn)
    $fell(reset_out_n) |-> !reset_out_n [*8])
    else $error("reset pulse too short");
  a_key_match: assert property (@(posedge core_clk) // RULE6
    disable iff (!rstn)
    keyWrite && !dedHit && !lowPowerOffResume && !faultPresent
      |=> keyAccepted == ($past(failsafeReleaseKey) == $past(expectedKey)))
    else $error("release key check wrong");
  a_release_cond: assert property (@(posedge core_clk) // RULE7
    disable iff (!rstn)
    $rose(failsafe_out_n) |-> !$past(faultPresent)
      && $past(resetErrCount) == 3'h0 && $past(keyAccepted))
    else $error("fail-safe released without conditions");
  a_start_count: assert property (@(posedge core_clk) // RULE8
    !rstn |=> resetErrCount == 3'h1 && !failsafe_out_n)
    else $error("start-up state wrong");
  a_ded_count: assert property (@(posedge core_clk) // RULE9
    disable iff (!rstn)
    dedHit && !lowPowerOffResume && resetErrCount != 3'h7
      |=> resetErrCount == $past(resetErrCount) + 3'h1)
    else $error("double error did not count");
  a_flag_sticky: assert property (@(posedge core_clk) // RULE10
    disable iff (!rstn)
    doubleErrorDetect && !errClear |=> doubleErrorDetect)
    else $error("double flag dropped without clear");

endmodule // sreg_guard

// File: sreg_mcu_model.sv
// Controller model that writes the fail-safe release key
`timescale 1ns/10ps
module sreg_mcu_model (
  input wire logic core_clk,
  input wire logic [7:0] watchdogSeedValue,
  input wire logic [2:0] resetErrCount,
  output logic keyWrite,
  output logic [7:0] failsafeReleaseKey
);
  initial begin
    keyWrite = 1'h0;
    failsafeReleaseKey = 8'h00;
  end
  // A low good flag sends a deliberately wrong key
  task automatic sendKey(input bit good);
    logic [7:0] k;
    int n;
    n = 0;
    while (resetErrCount !== 3'h0 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    k = {<<{watchdogSeedValue}};
    @(posedge core_clk);
    keyWrite <= 1'h1;
    failsafeReleaseKey <= ~k ^ (good ? 8'h00 : 8'h01);
    @(posedge core_clk);
    keyWrite <= 1'h0;
    // Released lines flip so a stale key is never seen
    failsafeReleaseKey <= ~failsafeReleaseKey;
  endtask
endmodule // sreg_mcu_model

// File: tb_top.sv
// Self-checking bench for the safety register guard
`timescale 1ns/10ps
module tb_top;
  typedef struct {string what; int k; logic [7:0] exp;} sreg_note_t;
  logic core_clk = 1'h0, rstn = 1'h0, safetyInitPhase = 1'h1;
  logic cfgWrite = 1'h0, faultPresent = 1'h0, lowPowerOffResume = 1'h0;
  logic goodRefreshDecrement = 1'h0, errClear = 1'h0, upsetInject = 1'h0;
  logic [1:0] cfgAddr = 2'h0, upsetAddr = 2'h0;
  logic [7:0] cfgData = 8'h00, watchdogSeedValue = 8'h00, img [4];
  logic [12:0] upsetMask = 13'h0000;
  logic [7:0] cfgReadData, failsafeReleaseKey;
  logic [2:0] resetErrCount;
  logic singleErrFlag, doubleErrorDetect, keyAccepted, keyWrite;
  logic reset_out_n, failsafe_out_n;
  int failures = 0, total_checks = 0, n = 0;
  sreg_note_t notes[$];
  always #50 core_clk = ~core_clk;
  sreg_guard DUT (.core_clk, .rstn, .safetyInitPhase, .cfgWrite, .cfgAddr,
    .cfgData, .cfgReadData, .keyWrite, .failsafeReleaseKey,
    .watchdogSeedValue, .faultPresent, .lowPowerOffResume,
    .goodRefreshDecrement, .errClear, .upsetInject, .upsetAddr, .upsetMask,
    .singleErrFlag, .doubleErrorDetect, .resetErrCount, .keyAccepted,
    .reset_out_n, .failsafe_out_n);
  sreg_mcu_model mcu (.core_clk, .watchdogSeedValue, .resetErrCount,
    .keyWrite, .failsafeReleaseKey);
  function automatic logic [7:0] seen(int k);
    case (k)
      0: return cfgReadData;
      1: return {7'h00, singleErrFlag};
      2: return {7'h00, doubleErrorDetect};
      3: return {5'h00, resetErrCount};
      4: return {7'h00, keyAccepted};
      5: return {7'h00, reset_out_n};
      default: return {7'h00, failsafe_out_n};
    endcase
  endfunction
  task automatic note(int k, logic [7:0] e, string w);
    notes.push_back('{w, k, e});
  endtask
  task automatic compare(sreg_note_t m);
    logic [7:0] s;
    s = seen(m.k);
    total_checks++;
    if (s !== m.exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", m.what, m.exp, s);
    end
  endtask
  // Outputs are settled by the falling edge
  always @(negedge core_clk) begin
    while (notes.size() > 0) compare(notes.pop_front());
  end
  task automatic tick(int c);
    repeat (c) @(posedge core_clk);
  endtask
  task automatic writeReg(int a, logic [7:0] d);
    @(posedge core_clk);
    cfgWrite <= 1'h1;
    cfgAddr <= 2'(a);
    cfgData <= d;
    @(posedge core_clk);
    cfgWrite <= 1'h0;
  endtask
  task automatic readReg(int a, logic [7:0] e);
    @(posedge core_clk);
    cfgAddr <= 2'(a);
    tick(2);
    note(0, e, "cfgReadData");
  endtask
  task automatic upset(int a, logic [12:0] m);
    @(posedge core_clk);
    upsetInject <= 1'h1;
    upsetAddr <= 2'(a);
    upsetMask <= m;
    @(posedge core_clk);
    upsetInject <= 1'h0;
  endtask
  task automatic strobe(int w);
    @(posedge core_clk);
    errClear <= (w == 0);
    goodRefreshDecrement <= (w == 1);
    lowPowerOffResume <= (w == 2);
    @(posedge core_clk);
    {errClear, goodRefreshDecrement, lowPowerOffResume} <= 3'h0;
  endtask
  task automatic conclude();
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #(3000 * 100);
    failures++;
    conclude();
  end
  initial begin
    void'($urandom(32'h62ac7696));
    tick(20);
    rstn <= 1'h1;
    watchdogSeedValue <= 8'($urandom);
    @(posedge core_clk);
    note(3, 8'h01, "resetErrCount");
    note(6, 8'h00, "failsafe_out_n");
    note(5, 8'h01, "reset_out_n");
    for (int i = 0; i < 4; i++) begin
      img[i] = 8'($urandom);
      writeReg(i, img[i]);
    end
    for (int i = 0; i < 4; i++) readReg(i, img[i]);
    upset(1, 13'h0010);
    tick(8);
    note(1, 8'h00, "singleErrFlag");
    safetyInitPhase <= 1'h0;
    tick(8);
    note(1, 8'h01, "singleErrFlag");
    readReg(1, img[1]);
    writeReg(0, ~img[0]);
    readReg(0, img[0]);
    note(1, 8'h01, "singleErrFlag");
    strobe(0);
    tick(1);
    note(1, 8'h00, "singleErrFlag");
    strobe(1);
    mcu.sendKey(1'b0);
    note(4, 8'h00, "keyAccepted");
    faultPresent <= 1'h1;
    mcu.sendKey(1'b1);
    tick(3);
    note(6, 8'h00, "failsafe_out_n");
    faultPresent <= 1'h0;
    mcu.sendKey(1'b1);
    note(4, 8'h01, "keyAccepted");
    tick(2);
    note(6, 8'h01, "failsafe_out_n");
    strobe(2);
    tick(1);
    note(3, 8'h01, "resetErrCount");
    note(6, 8'h00, "failsafe_out_n");
    strobe(1);
    upset(2, 13'h0006);
    while (doubleErrorDetect !== 1'h1 && n < 10) begin
      @(negedge core_clk);
      n++;
    end
    note(2, 8'h01, "doubleErrorDetect");
    note(3, 8'h01, "resetErrCount");
    note(5, 8'h00, "reset_out_n");
    note(6, 8'h00, "failsafe_out_n");
    tick(2);
    conclude();
  end
endmodule // tb_top
